// ### src/mmt_timer.sv
// multi-method 16-bit timer/counter with AHB-Lite register slave
// assumes one clock hclk; clock sources arrive as synchronous tick inputs
// ****************************************************************
// timer top
// ****************************************************************
// Behaviour
// - 16-bit count steps by one per divided tick, direction from method.
// - divided tick from high or low speed source through 2-bit prescaler.
// - counting only while enable bit is one.
// - writing clear bit zeroes count; clear bit returns to zero itself.
// - trigger select 00 counts continuously whenever enabled.
// - trigger select 01 counts only while capture timer output is high.
// - method 00 up; above limit wraps to zero next tick, sets overflow.
// - method 01 up; at limit turns down next tick, no overflow.
// - method 01 sets overflow at zero going down, then counts up.
// - method 10 two independent byte counters, each bounded by limit byte.
// - split bytes wrap after equal; only low byte wrap sets overflow.
// - method 11 low byte counts; on wrap, overflow and upper byte increments.
// - overflow sets flag; interrupt only when enable and global enable set.
// - clearing flag withdraws request; next overflow sets it again.
// - overflow wakes from idle; no interrupt while chip sleeps.
// - count readable any time without disturbing counting.
// - counter works in active, idle and wait modes.
//
// Register access over AHB-Lite and the register offsets were decided locally.
module mmt_timer #(
   parameter int PRESC_W = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic high_speed_clock,
   input wire logic low_speed_clock,
   input wire logic capture_timer_output,
   output logic irq,
   output logic wake
);
   import mmt_pkg::*;

   // ****************************************************************
   // registers and state
   // ****************************************************************
   logic [1:0] trigger_source_sel;
   logic [1:0] count_method_sel;
   logic counter_clear_bit;
   logic counter_enable_bit;
   logic [15:0] period_limit;
   logic [PRESC_W-1:0] clock_prescale_sel;
   logic [1:0] count_clock_source_sel;
   logic overflow_irq_flag;
   logic overflow_irq_enable;
   logic global_irq_enable;
   logic chip_sleep;
   logic [15:0] count_value_reg;
   logic count_down;
   logic [7:0] presc_cnt;
   logic src_tick;
   logic divided_count_clock;
   logic step;
   logic [15:0] next_count;
   logic next_down;
   logic ovf_event;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] wdat;
   logic wr_ctrl;
   logic wr_stat;
   logic src_prev;

   // ahb address phase capture
   logic ap_valid;
   assign ap_valid = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wdat = hwdata;

   // latch write address for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= ap_valid & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   assign wr_ctrl = wr_pend && wr_addr == MMT_CTRL_OFS;
   assign wr_stat = wr_pend && wr_addr == MMT_IRQ_STAT_OFS;

   // read data, registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ap_valid && !hwrite) begin
         case (haddr[7:0])
            MMT_CTRL_OFS: hrdata <= {26'h0, counter_enable_bit, counter_clear_bit,
                                     count_method_sel, trigger_source_sel};
            MMT_COUNT_OFS: hrdata <= {16'h0, count_value_reg};
            MMT_LIMIT_OFS: hrdata <= {16'h0, period_limit};
            MMT_CLKSEL_OFS: hrdata <= {24'h0, count_clock_source_sel,
                                       (PRESC_W)'(clock_prescale_sel), 4'h0};
            MMT_IRQ_STAT_OFS: hrdata <= {31'h0, overflow_irq_flag};
            MMT_IRQ_MASK_OFS: hrdata <= {30'h0, global_irq_enable, overflow_irq_enable};
            MMT_POWER_OFS: hrdata <= {31'h0, chip_sleep};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // control register; clear bit self-returns after one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trigger_source_sel <= 2'h0;
         count_method_sel <= 2'h0;
         counter_clear_bit <= 1'b0;
         counter_enable_bit <= 1'b0;
      end else if (wr_ctrl) begin
         trigger_source_sel <= wdat[MMT_TRIG_LSB +: 2];
         count_method_sel <= wdat[MMT_METHOD_LSB +: 2];
         counter_clear_bit <= wdat[MMT_CLEAR_BIT];
         counter_enable_bit <= wdat[MMT_ENABLE_BIT];
      end else begin
         counter_clear_bit <= 1'b0;
      end
   end

   // limit, clock select, mask, power registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_limit <= MMT_LIMIT_RST;
         clock_prescale_sel <= '0;
         count_clock_source_sel <= 2'h0;
         overflow_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
         chip_sleep <= 1'b0;
      end else if (wr_pend) begin
         if (wr_addr == MMT_LIMIT_OFS)
            period_limit <= wdat[15:0];
         if (wr_addr == MMT_CLKSEL_OFS) begin
            clock_prescale_sel <= wdat[MMT_PRESC_LSB +: PRESC_W];
            count_clock_source_sel <= wdat[MMT_SRC_LSB +: 2];
         end
         if (wr_addr == MMT_IRQ_MASK_OFS) begin
            overflow_irq_enable <= wdat[MMT_OVF_BIT];
            global_irq_enable <= wdat[MMT_GIE_BIT];
         end
         if (wr_addr == MMT_POWER_OFS)
            chip_sleep <= wdat[MMT_SLEEP_BIT];
      end
   end

   // ****************************************************************
   // count clock: source select and prescaler
   // ****************************************************************
   // rising edge of chosen source gives one tick
   logic src_lvl;
   assign src_lvl = count_clock_source_sel[0] ? low_speed_clock : high_speed_clock;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         src_prev <= 1'b0;
      else
         src_prev <= src_lvl;
   end
   assign src_tick = src_lvl & ~src_prev;

   // divide ticks by 2^(sel+1)
   function automatic logic [7:0] presc_top(input logic [PRESC_W-1:0] sel);
      presc_top = 8'((16'h2 << sel) - 16'h1);
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         presc_cnt <= 8'h00;
      else if (src_tick)
         presc_cnt <= (presc_cnt >= presc_top(clock_prescale_sel)) ? 8'h00 : presc_cnt + 8'h01;
   end
   assign divided_count_clock = src_tick && presc_cnt >= presc_top(clock_prescale_sel);

   // gate by enable and trigger; clock runs in all non-sleep modes
   assign step = divided_count_clock && counter_enable_bit &&
                 (trigger_source_sel == MMT_T_ALWAYS ||
                  (trigger_source_sel == MMT_T_CAPTURE && capture_timer_output));

   // ****************************************************************
   // counting methods
   // ****************************************************************
   // next count, direction and overflow per method
   always_comb begin
      next_count = count_value_reg;
      next_down = count_down;
      ovf_event = 1'b0;
      case (mmt_method_t'(count_method_sel))
         MMT_M_UP16: begin
            next_down = 1'b0;
            if (count_value_reg > period_limit || count_value_reg == 16'hffff) begin
               next_count = 16'h0000;
               ovf_event = 1'b1;
            end else
               next_count = count_value_reg + 16'h0001;
         end
         MMT_M_UPDOWN: begin
            if (!count_down) begin
               if (count_value_reg >= period_limit) begin
                  next_down = 1'b1;
                  next_count = count_value_reg - 16'h0001;
               end else
                  next_count = count_value_reg + 16'h0001;
            end else if (count_value_reg == 16'h0001 || count_value_reg == 16'h0000) begin
               next_count = 16'h0000;
               next_down = 1'b0;
               ovf_event = 1'b1;
            end else
               next_count = count_value_reg - 16'h0001;
         end
         MMT_M_SPLIT8: begin
            next_down = 1'b0;
            next_count[15:8] = (count_value_reg[15:8] == period_limit[15:8]) ? 8'h00 :
                               count_value_reg[15:8] + 8'h01;
            next_count[7:0] = (count_value_reg[7:0] == period_limit[7:0]) ? 8'h00 :
                              count_value_reg[7:0] + 8'h01;
            ovf_event = count_value_reg[7:0] == period_limit[7:0];
         end
         MMT_M_CASCADE: begin
            next_down = 1'b0;
            if (count_value_reg[7:0] == period_limit[7:0]) begin
               next_count[7:0] = 8'h00;
               next_count[15:8] = count_value_reg[15:8] + 8'h01;
               ovf_event = 1'b1;
            end else
               next_count[7:0] = count_value_reg[7:0] + 8'h01;
         end
         default: next_count = count_value_reg;
      endcase
   end

   // count register: clear wins, else step, else hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_value_reg <= MMT_COUNT_RST;
         count_down <= 1'b0;
      end else if (counter_clear_bit) begin
         count_value_reg <= MMT_COUNT_RST;
         count_down <= 1'b0;
      end else if (step) begin
         count_value_reg <= next_count;
         count_down <= next_down;
      end
   end

   // ****************************************************************
   // interrupt
   // ****************************************************************
   // sticky flag, write one clears, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         overflow_irq_flag <= 1'b0;
      else if (step && ovf_event)
         overflow_irq_flag <= 1'b1;
      else if (wr_stat && wdat[MMT_OVF_BIT])
         overflow_irq_flag <= 1'b0;
   end

   // request gated by both enables and sleep
   assign irq = overflow_irq_flag && overflow_irq_enable && global_irq_enable && !chip_sleep;
   assign wake = irq;

   // ****************************************************************
   // assertions
   // ****************************************************************
   irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == (overflow_irq_flag && overflow_irq_enable && global_irq_enable && !chip_sleep))
      else $error("irq gating wrong");
   ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && ovf_event) |=> overflow_irq_flag)
      else $error("overflow flag not set");
   clr_self_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (counter_clear_bit && !wr_ctrl) |=> !counter_clear_bit && count_value_reg == 16'h0000)
      else $error("clear bit stuck");
   hold_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!step && !counter_clear_bit) |=> $stable(count_value_reg) && $stable(count_down))
      else $error("count moved while idle");
   up_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h0 && count_value_reg > period_limit)
      |=> count_value_reg == 16'h0000)
      else $error("up wrap missed");
   turn_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h1 && !count_down
       && count_value_reg == period_limit && period_limit != 16'h0000) |=> count_down && !$rose(overflow_irq_flag))
      else $error("updown turn wrong");
   split_hi_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h2 && count_value_reg[15:8] == period_limit[15:8])
      |=> count_value_reg[15:8] == 8'h00)
      else $error("split high wrap wrong");
   cascade_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h3 && count_value_reg[7:0] == period_limit[7:0])
      |=> count_value_reg[15:8] == $past(count_value_reg[15:8]) + 8'h01 && count_value_reg[7:0] == 8'h00)
      else $error("cascade carry wrong");
   gate_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (trigger_source_sel == 2'h1 && !capture_timer_output) |-> !step)
      else $error("trigger gate open");
   updown_bottom_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h1 && count_down && count_value_reg == 16'h0001)
      |=> !count_down && count_value_reg == 16'h0000 && overflow_irq_flag)
      else $error("updown bottom turn wrong");
   split_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !counter_clear_bit && count_method_sel == 2'h2 && count_value_reg[7:0] == period_limit[7:0])
      |=> count_value_reg[7:0] == 8'h00 && overflow_irq_flag)
      else $error("split low wrap wrong");
   split_hi_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && count_method_sel == 2'h2 && count_value_reg[7:0] != period_limit[7:0])
      |=> !$rose(overflow_irq_flag))
      else $error("split high wrap flagged");
   enable_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !counter_enable_bit |-> !step)
      else $error("step while disabled");
   flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stat && wdat[MMT_OVF_BIT] && !(step && ovf_event)) |=> !overflow_irq_flag)
      else $error("flag clear ignored");
   sleep_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      chip_sleep |-> !irq && !wake)
      else $error("interrupt while asleep");
endmodule

// ### src/mmt_pkg.sv
// package for the multi-method timer/counter: offsets, fields, reset values, enums
// assumes a 32-bit AHB-Lite slave, word-aligned registers
package mmt_pkg;
   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] MMT_CTRL_OFS = 8'h04;
   localparam logic [7:0] MMT_COUNT_OFS = 8'h08;
   localparam logic [7:0] MMT_LIMIT_OFS = 8'h0c;
   localparam logic [7:0] MMT_CLKSEL_OFS = 8'h10;
   localparam logic [7:0] MMT_IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] MMT_IRQ_MASK_OFS = 8'h18;
   localparam logic [7:0] MMT_POWER_OFS = 8'h1c;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int MMT_TRIG_LSB = 0;
   localparam int MMT_METHOD_LSB = 2;
   localparam int MMT_CLEAR_BIT = 4;
   localparam int MMT_ENABLE_BIT = 5;
   localparam int MMT_PRESC_LSB = 4;
   localparam int MMT_SRC_LSB = 6;
   localparam int MMT_OVF_BIT = 0;
   localparam int MMT_GIE_BIT = 1;
   localparam int MMT_SLEEP_BIT = 0;
   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] MMT_LIMIT_RST = 16'hffff;
   localparam logic [15:0] MMT_COUNT_RST = 16'h0000;
   // ****************************************************************
   // enumerations
   // ****************************************************************
   typedef enum logic [1:0] {
      MMT_M_UP16,
      MMT_M_UPDOWN,
      MMT_M_SPLIT8,
      MMT_M_CASCADE
   } mmt_method_t;
   typedef enum logic [1:0] {
      MMT_T_ALWAYS,
      MMT_T_CAPTURE,
      MMT_T_RSV2,
      MMT_T_RSV3
   } mmt_trig_t;
endpackage

// ### testbench/mmt_timer_tb.sv
// bench for the multi-method timer: bus tasks, counting sequences, gating, interrupt checks
// assumes mmt_pkg and mmt_timer compiled first; clock sources driven as slow levels on hclk
module mmt_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mmt_pkg::*;
   // ****************************************************************
   // signals and design
   // ****************************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hs_src = 1'b0;
   logic ls_src = 1'b0;
   logic cap = 1'b0;
   logic src_low = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic wake;
   logic [31:0] rv;
   logic [15:0] c0;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   mmt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .high_speed_clock(hs_src), .low_speed_clock(ls_src), .capture_timer_output(cap), .irq(irq), .wake(wake));
   // 200 MHz clock
   always #2.5 hclk = ~hclk;
   // hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total = err_total + 1;
         final_report();
      end
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task final_report;
      if (err_total == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one single AHB-Lite transfer, entered just after a rising edge
   task bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task bus_wr(input logic [7:0] a, input logic [31:0] d);
      bus_xfer(a, 1'b1, d, rv);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      bus_xfer(a, 1'b0, 32'h0, rv);
      chk(name, rv, exp);
      chk("response", {31'h0, hresp}, 32'h0);
      chk("ready", {31'h0, hreadyout}, 32'h1);
   endtask
   // source rising edges on the selected source line
   task tick(input int n);
      repeat (n) begin
         if (src_low) ls_src <= 1'b1;
         else hs_src <= 1'b1;
         repeat (2) @(posedge hclk);
         hs_src <= 1'b0;
         ls_src <= 1'b0;
         repeat (2) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask
   // count must move by inc over n source edges
   task tick_chk(input int n, input logic [15:0] inc);
      bus_xfer(MMT_COUNT_OFS, 1'b0, 32'h0, rv);
      c0 = rv[15:0];
      tick(n);
      rd_chk(MMT_COUNT_OFS, {16'h0, c0 + inc}, "count step");
   endtask
   task irq_chk(input logic v);
      @(posedge hclk);
      chk("irq", {31'h0, irq}, {31'h0, v});
      chk("wake", {31'h0, wake}, {31'h0, v});
   endtask
   // configure in software order, then step once per two high-speed edges
   task run_seq(input logic [1:0] m, input logic [15:0] lim, input logic [15:0] e [5], input logic [4:0] fl);
      bus_wr(MMT_IRQ_STAT_OFS, 32'h1);
      bus_wr(MMT_CLKSEL_OFS, 32'h0);
      bus_wr(MMT_CTRL_OFS, {28'h0, m, 2'h0});
      bus_wr(MMT_LIMIT_OFS, {16'h0, lim});
      bus_wr(MMT_CTRL_OFS, {26'h0, 2'b01, m, 2'h0});
      bus_wr(MMT_CTRL_OFS, {26'h0, 2'b10, m, 2'h0});
      rd_chk(MMT_COUNT_OFS, 32'h0, "count after clear");
      for (int i = 0; i < 5; i++) begin
         tick(2);
         rd_chk(MMT_COUNT_OFS, {16'h0, e[i]}, "method count");
         rd_chk(MMT_IRQ_STAT_OFS, {31'h0, fl[i]}, "overflow flag");
         if (fl[i]) bus_wr(MMT_IRQ_STAT_OFS, 32'h1);
      end
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(MMT_LIMIT_OFS, 32'h0000ffff, "limit reset");
      rd_chk(MMT_COUNT_OFS, 32'h0, "count reset");
      rd_chk(MMT_CTRL_OFS, 32'h0, "ctrl reset");
      rd_chk(MMT_IRQ_STAT_OFS, 32'h0, "flag reset");
      bus_wr(8'h20, 32'hffffffff);
      rd_chk(8'h20, 32'h0, "unmapped");
      run_seq(2'b00, 16'h0003, '{16'h1, 16'h2, 16'h3, 16'h4, 16'h0}, 5'b10000);
      run_seq(2'b01, 16'h0002, '{16'h1, 16'h2, 16'h1, 16'h0, 16'h1}, 5'b01000);
      run_seq(2'b10, 16'h0102, '{16'h0101, 16'h0002, 16'h0100, 16'h0001, 16'h0102}, 5'b00100);
      run_seq(2'b11, 16'h0001, '{16'h0001, 16'h0100, 16'h0101, 16'h0200, 16'h0201}, 5'b01010);
      // overflow interrupt: mask, global enable, sleep, write-one-to-clear
      bus_wr(MMT_LIMIT_OFS, 32'h0);
      bus_wr(MMT_CTRL_OFS, 32'h10);
      bus_wr(MMT_CTRL_OFS, 32'h20);
      tick(4);
      rd_chk(MMT_IRQ_STAT_OFS, 32'h1, "wrap flag");
      irq_chk(1'b0);
      bus_wr(MMT_IRQ_MASK_OFS, 32'h1);
      irq_chk(1'b0);
      bus_wr(MMT_IRQ_MASK_OFS, 32'h2);
      irq_chk(1'b0);
      bus_wr(MMT_IRQ_MASK_OFS, 32'h3);
      irq_chk(1'b1);
      bus_wr(MMT_POWER_OFS, 32'h1);
      irq_chk(1'b0);
      bus_wr(MMT_POWER_OFS, 32'h0);
      irq_chk(1'b1);
      bus_wr(MMT_IRQ_STAT_OFS, 32'h0);
      rd_chk(MMT_IRQ_STAT_OFS, 32'h1, "flag kept");
      bus_wr(MMT_IRQ_STAT_OFS, 32'h1);
      irq_chk(1'b0);
      tick(4);
      irq_chk(1'b1);
      bus_wr(MMT_IRQ_STAT_OFS, 32'h1);
      bus_wr(MMT_IRQ_MASK_OFS, 32'h0);
      // enable and trigger gating
      bus_wr(MMT_LIMIT_OFS, 32'hffff);
      bus_wr(MMT_CTRL_OFS, 32'h0);
      tick_chk(6, 16'h0);
      rd_chk(MMT_IRQ_STAT_OFS, 32'h0, "flag idle");
      for (int t = 0; t < 4; t++) begin
         for (int c = 0; c < 2; c++) begin
            cap <= c[0];
            bus_wr(MMT_CTRL_OFS, 32'h20 | t);
            tick_chk(4, (t == 0 || (t == 1 && c == 1)) ? 16'h2 : 16'h0);
         end
      end
      cap <= 1'b0;
      // clear while running
      bus_wr(MMT_CTRL_OFS, 32'h30);
      // clear bit lands at the data edge; count zeroes one edge later
      @(posedge hclk);
      rd_chk(MMT_COUNT_OFS, 32'h0, "count cleared");
      rd_chk(MMT_CTRL_OFS, 32'h20, "clear bit returns");
      // source select and prescale ratios
      bus_wr(MMT_CLKSEL_OFS, 32'h40);
      tick_chk(4, 16'h0);
      src_low = 1'b1;
      tick_chk(4, 16'h2);
      src_low = 1'b0;
      for (int s = 0; s < 4; s++) begin
         bus_wr(MMT_CLKSEL_OFS, s << 4);
         tick_chk(2 << s, 16'h1);
      end
      final_report();
   end
endmodule
